/* File: bench/bridge_interrupt_eeprom_control_tb_top.sv */
// Self-checking bench for the bridge interrupt and serial ROM control block
`timescale 1ns/1ps
module bridge_interrupt_eeprom_control_tb_top
  import bridge_ctl_pkg::*;
;
  typedef struct {logic h; logic [7:0] a; logic [31:0] e; logic [31:0] m;} rd_note_s;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [1:0]  sel = 2'b00;
  logic        wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic abort_status = 0, abort_by_direct = 0, retry_seen = 0, xfer_done = 0, fitted = 0;
  logic chan0_status = 0, chan1_status = 0, selftest_bit = 0, local_irq_pin = 0;
  logic gp_input_pin = 0, reload_done = 0, init_bypass_n = 1, last_retry;
  logic [31:0] host_rdata, loc_rdata, ics_v, eio_v, rnd;
  logic host_retry, retry_abort, host_irq, local_irq, local_syserr_out_n, gp_output_pin;
  logic rom_clk_pin, rom_sel_pin, rom_data_out_pin, rom_data_in_pin, rom_detect_pin;
  logic reload_start, local_reset_out_n;
  wire  [15:0] cmd;
  int errors = 0, checks_done = 0, cyc = 0, ra_cnt = 0, rs_cnt = 0, seed = 75592;
  logic [1:0]  rd_q = 2'b00;
  rd_note_s    notes[$];
  rd_note_s    mon_n;

  bridge_interrupt_eeprom_control dut (
    .clock(clock), .sys_rst(sys_rst), .host_sel(sel[1]), .host_wr(wr),
    .host_addr({1'b0, addr[6:0]}),
    .host_wdata(wdata), .host_rdata(host_rdata), .host_retry(host_retry), .loc_sel(sel[0]),
    .loc_wr(wr), .loc_addr({1'b1, addr[6:0]}), .loc_wdata(wdata), .loc_rdata(loc_rdata),
    .abort_status(abort_status), .abort_by_direct(abort_by_direct), .retry_seen(retry_seen),
    .xfer_done(xfer_done), .retry_abort(retry_abort), .chan0_status(chan0_status),
    .chan1_status(chan1_status), .selftest_bit(selftest_bit), .local_irq_pin(local_irq_pin),
    .host_irq(host_irq), .local_irq(local_irq), .local_syserr_out_n(local_syserr_out_n),
    .dma_read_cmd(cmd[3:0]), .dma_write_cmd(cmd[7:4]), .direct_read_cmd(cmd[11:8]),
    .direct_write_cmd(cmd[15:12]), .gp_output_pin(gp_output_pin), .gp_input_pin(gp_input_pin),
    .rom_clk_pin(rom_clk_pin), .rom_sel_pin(rom_sel_pin), .rom_data_out_pin(rom_data_out_pin),
    .rom_data_in_pin(rom_data_in_pin), .rom_detect_pin(rom_detect_pin),
    .reload_start(reload_start), .reload_done(reload_done),
    .local_reset_out_n(local_reset_out_n), .init_bypass_n(init_bypass_n)
  );
  serial_rom_model rom (
    .clock(clock), .rom_clk_pin(rom_clk_pin), .rom_sel_pin(rom_sel_pin),
    .rom_data_out_pin(rom_data_out_pin), .fitted(fitted), .rom_data_in_pin(rom_data_in_pin),
    .rom_detect_pin(rom_detect_pin)
  );

  // ********************************
  // Clock, monitors and access tasks
  // ********************************
  always #5 clock = ~clock;
  always @(posedge clock) begin
    rd_q <= sel & {~wr, ~wr};
    if (retry_abort === 1'b1) ra_cnt++;
    if (reload_start === 1'b1) rs_cnt++;
    cyc++;
    // Ceiling well above the thousand or so cycles the sequence needs
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  always @(negedge clock) if (rd_q != 2'b00 && notes.size() > 0) begin
    mon_n = notes.pop_front();
    chk($sformatf("rdata_%h", mon_n.a), mon_n.e & mon_n.m,
        (mon_n.h ? host_rdata : loc_rdata) & mon_n.m);
  end
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction : b
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic put(input logic h, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sel <= {h, ~h};
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    sel <= 2'b00;
    wr <= 1'b0;
    // Registered outputs settle one edge after the register itself
    repeat (2) @(posedge clock);
  endtask : put
  task automatic get(input logic h, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    sel <= {h, ~h};
    addr <= a;
    notes.push_back('{h, a, e, m});
    @(negedge clock);
    last_retry = host_retry;
    @(posedge clock);
    sel <= 2'b00;
  endtask : get
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clock);
      retry_seen <= 1'b1;
    end
    @(posedge clock);
    retry_seen <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : pulses
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    get(1, OFF_ICS_HOST, ICS_RESET, ~b(B_ABORT_OWNER));
    chk("retry", 1, last_retry);
    get(1, OFF_EIO_HOST, EIO_RESET, ~b(B_ROM_RD));
    chk("cmds", 32'h767e, cmd);
    chk("gp_out", 1, gp_output_pin);
    eio_v = EIO_RESET | b(B_INIT_DONE);
    put(1, OFF_EIO_HOST, eio_v);
    get(1, OFF_EIO_HOST, eio_v, b(B_INIT_DONE));
    chk("retry", 0, last_retry);
    rnd = $random(seed);
    eio_v[15:0] = rnd[15:0];
    put(1, OFF_EIO_HOST, eio_v);
    chk("cmds", rnd[15:0], cmd);
    ics_v = ICS_RESET | b(B_HOST_BELL_EN);
    put(1, OFF_ICS_HOST, ics_v);
    rnd = $random(seed) | 32'h1;
    put(0, OFF_HBELL_LOC, rnd);
    get(1, OFF_HBELL_HOST, rnd, '1);
    repeat (2) @(posedge clock);
    chk("host_irq", 1, host_irq);
    get(1, OFF_ICS_HOST, ics_v | b(B_HOST_BELL_ACT), 32'hffff);
    put(1, OFF_ICS_HOST, ics_v & ~b(B_HOST_MASTER));
    chk("host_irq", 0, host_irq);
    put(1, OFF_ICS_HOST, ics_v);
    put(1, OFF_HBELL_HOST, rnd & 32'hffff_fffe);
    get(1, OFF_HBELL_HOST, 32'h1, '1);
    chk("host_irq", 1, host_irq);
    put(1, OFF_HBELL_HOST, 32'h1);
    chk("host_irq", 0, host_irq);
    // Both sides hit the same bell in one cycle
    @(posedge clock);
    sel <= 2'b11;
    wr <= 1'b1;
    addr <= OFF_HBELL_HOST;
    wdata <= 32'h1;
    @(posedge clock);
    sel <= 2'b00;
    wr <= 1'b0;
    get(1, OFF_HBELL_HOST, 32'h1, '1);
    put(1, OFF_HBELL_HOST, 32'h1);
    put(1, OFF_ICS_HOST, ics_v | 32'he000);
    get(1, OFF_ICS_HOST, ics_v, 32'hffff);
    ics_v = ics_v | b(B_ABORT_EN) | b(B_SYSERR_EN) | b(B_LIN_EN);
    put(1, OFF_ICS_HOST, ics_v);
    for (int i = 0; i < 2; i++) begin
      abort_by_direct <= (i == 0);
      abort_status <= 1'b1;
      repeat (3) @(posedge clock);
      chk("host_irq", 1, host_irq);
      chk("syserr_n", 0, local_syserr_out_n);
      get(1, OFF_ICS_HOST, b(B_ABORT_ACT) | (i * b(B_ABORT_OWNER)), 32'h0500_4000);
      abort_status <= 1'b0;
      repeat (3) @(posedge clock);
      chk("host_irq", 0, host_irq);
    end
    local_irq_pin <= 1'b1;
    repeat (8) @(posedge clock);
    chk("host_irq", 1, host_irq);
    get(1, OFF_ICS_HOST, b(B_LIN_ACT), b(B_LIN_ACT));
    local_irq_pin <= 1'b0;
    repeat (8) @(posedge clock);
    chk("host_irq", 0, host_irq);
    ics_v = ics_v | b(B_LOC_BELL_EN) | b(B_CH0_EN) | b(B_CH1_EN) | b(B_RETRY_EN);
    put(1, OFF_ICS_HOST, ics_v);
    rnd = $random(seed) | 32'h1;
    put(1, OFF_LBELL_HOST, rnd);
    chk("local_irq", 1, local_irq);
    get(0, OFF_LBELL_LOC, rnd, '1);
    get(0, OFF_ICS_LOC, b(B_LOC_BELL_ACT), b(B_LOC_BELL_ACT));
    put(0, OFF_LBELL_LOC, rnd);
    chk("local_irq", 0, local_irq);
    for (int i = 0; i < 3; i++) begin
      chan0_status <= (i == 0);
      chan1_status <= (i == 1);
      selftest_bit <= (i == 2);
      repeat (2) @(posedge clock);
      chk("local_irq", 1, local_irq);
      get(0, OFF_ICS_LOC, b(B_CH0_ACT + i), 32'h00e0_0000);
    end
    selftest_bit <= 1'b0;
    repeat (2) @(posedge clock);
    chk("local_irq", 0, local_irq);
    pulses(255);
    chk("retry_abort", 0, ra_cnt);
    put(1, OFF_ICS_HOST, ics_v | b(B_RETRY_ABORT));
    get(1, OFF_ICS_HOST, b(B_RETRY_ABORT), b(B_RETRY_ABORT));
    pulses(1);
    chk("retry_abort", 1, ra_cnt);
    get(1, OFF_ICS_HOST, 32'h0, b(B_RETRY_ABORT));
    pulses(100);
    xfer_done <= 1'b1;
    @(posedge clock);
    xfer_done <= 1'b0;
    pulses(200);
    put(1, OFF_ICS_HOST, ics_v & ~b(B_RETRY_EN));
    pulses(300);
    chk("retry_abort", 1, ra_cnt);
    for (int i = 0; i < 2; i++) begin
      eio_v = eio_v | b(B_ROM_SEL);
      eio_v[B_ROM_WR] = (i == 0);
      // Select and data settle before the clock bit rises
      put(1, OFF_EIO_HOST, eio_v);
      put(1, OFF_EIO_HOST, eio_v | b(B_ROM_CLK));
      put(1, OFF_EIO_HOST, eio_v);
      repeat (6) @(posedge clock);
      get(1, OFF_EIO_HOST, (i == 0) * b(B_ROM_RD), b(B_ROM_RD));
    end
    fitted <= 1'b1;
    gp_input_pin <= 1'b1;
    eio_v[B_GP_OUT] = 1'b0;
    put(1, OFF_EIO_HOST, eio_v);
    repeat (6) @(posedge clock);
    chk("gp_out", 0, gp_output_pin);
    get(1, OFF_EIO_HOST, b(B_ROM_PRES) | b(B_GP_IN), b(B_ROM_PRES) | b(B_GP_IN));
    for (int i = 0; i < 2; i++) put(1, OFF_EIO_HOST, eio_v | b(B_RELOAD));
    chk("reload", 1, rs_cnt);
    reload_done <= 1'b1;
    @(posedge clock);
    reload_done <= 1'b0;
    get(1, OFF_EIO_HOST, 32'h0, b(B_RELOAD));
    put(1, OFF_EIO_HOST, eio_v | b(B_SOFT_RST));
    put(0, OFF_HBELL_LOC, rnd);
    put(0, OFF_EIO_LOC, eio_v);
    chk("lreset_n", 0, local_reset_out_n);
    get(1, OFF_HBELL_HOST, 32'h0, '1);
    get(1, OFF_ICS_HOST, ics_v & ~b(B_RETRY_EN), 32'h000f_1f07);
    put(1, OFF_EIO_HOST, eio_v);
    chk("lreset_n", 1, local_reset_out_n);
    init_bypass_n <= 1'b0;
    put(1, OFF_EIO_HOST, eio_v & ~b(B_INIT_DONE));
    repeat (6) @(posedge clock);
    get(1, OFF_EIO_HOST, b(B_INIT_DONE), b(B_INIT_DONE));
    repeat (4) @(posedge clock);
    end_of_test();
  end
endmodule : bridge_interrupt_eeprom_control_tb_top

/* File: bench/serial_rom_model.sv */
// Serial ROM stand-in facing the bit-banged ROM pins of the bridge
`timescale 1ns/1ps
module serial_rom_model (
  input  wire logic clock,
  input  wire logic rom_clk_pin,
  input  wire logic rom_sel_pin,
  input  wire logic rom_data_out_pin,
  input  wire logic fitted,
  output logic      rom_data_in_pin,
  output logic      rom_detect_pin
);
  logic [7:0] shift_r = 8'h00;
  logic       idle_r  = 1'b0;
  // Bit taken on software clock rise while selected
  always @(posedge rom_clk_pin) if (rom_sel_pin) shift_r <= {shift_r[6:0], rom_data_out_pin};
  // Deselected output wanders, so a stale level never passes for data
  always @(posedge clock) idle_r <= ~idle_r;
  assign rom_data_in_pin = rom_sel_pin ? shift_r[0] : idle_r;
  assign rom_detect_pin  = fitted;
endmodule : serial_rom_model

/* File: logic/bridge_ctl_pkg.sv */
// Constants shared by the bridge interrupt and serial-ROM control logic
package bridge_ctl_pkg;

  // ********************************
  // Register offsets, host and local views
  // ********************************
  localparam logic [7:0] OFF_LBELL_HOST = 8'h60;
  localparam logic [7:0] OFF_HBELL_HOST = 8'h64;
  localparam logic [7:0] OFF_ICS_HOST   = 8'h68;
  localparam logic [7:0] OFF_EIO_HOST   = 8'h6c;
  localparam logic [7:0] OFF_LBELL_LOC  = 8'he0;
  localparam logic [7:0] OFF_HBELL_LOC  = 8'he4;
  localparam logic [7:0] OFF_ICS_LOC    = 8'he8;
  localparam logic [7:0] OFF_EIO_LOC    = 8'hec;

  // ********************************
  // Interrupt control/status fields
  // ********************************
  localparam int B_SYSERR_EN     = 0;
  localparam int B_HOST_MASTER   = 8;
  localparam int B_HOST_BELL_EN  = 9;
  localparam int B_ABORT_EN      = 10;
  localparam int B_LIN_EN        = 11;
  localparam int B_RETRY_EN      = 12;
  localparam int B_HOST_BELL_ACT = 13;
  localparam int B_ABORT_ACT     = 14;
  localparam int B_LIN_ACT       = 15;
  localparam int B_LOC_MASTER    = 16;
  localparam int B_LOC_BELL_EN   = 17;
  localparam int B_CH0_EN        = 18;
  localparam int B_CH1_EN        = 19;
  localparam int B_LOC_BELL_ACT  = 20;
  localparam int B_CH0_ACT       = 21;
  localparam int B_CH1_ACT       = 22;
  localparam int B_SELFTEST_ACT  = 23;
  localparam int B_ABORT_OWNER   = 24;
  localparam int B_RETRY_ABORT   = 27;
  localparam logic [31:0] ICS_WR_MASK = 32'h000f_1f07;
  localparam logic [31:0] ICS_RESET   = 32'h0001_0100;

  // ********************************
  // Serial ROM and I/O control fields
  // ********************************
  localparam int B_GP_OUT     = 16;
  localparam int B_GP_IN      = 17;
  localparam int B_ROM_CLK    = 24;
  localparam int B_ROM_SEL    = 25;
  localparam int B_ROM_WR     = 26;
  localparam int B_ROM_RD     = 27;
  localparam int B_ROM_PRES   = 28;
  localparam int B_RELOAD     = 29;
  localparam int B_SOFT_RST   = 30;
  localparam int B_INIT_DONE  = 31;
  localparam logic [31:0] EIO_WR_MASK = 32'h0701_ffff;
  localparam logic [31:0] EIO_RESET   = 32'h0001_767e;

  // ********************************
  // Retry limit
  // ********************************
  localparam logic [8:0] RETRY_LIMIT = 9'h100;

endpackage : bridge_ctl_pkg

/* File: logic/bridge_interrupt_eeprom_control.sv */
// Interrupt, doorbell, serial ROM and local control registers of the bridge
`timescale 1ns/1ps
module bridge_interrupt_eeprom_control
  import bridge_ctl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        host_sel,
  input  wire logic        host_wr,
  input  wire logic [7:0]  host_addr,
  input  wire logic [31:0] host_wdata,
  output logic      [31:0] host_rdata,
  output logic             host_retry,
  input  wire logic        loc_sel,
  input  wire logic        loc_wr,
  input  wire logic [7:0]  loc_addr,
  input  wire logic [31:0] loc_wdata,
  output logic      [31:0] loc_rdata,
  input  wire logic        abort_status,
  input  wire logic        abort_by_direct,
  input  wire logic        retry_seen,
  input  wire logic        xfer_done,
  output logic             retry_abort,
  input  wire logic        chan0_status,
  input  wire logic        chan1_status,
  input  wire logic        selftest_bit,
  input  wire logic        local_irq_pin,
  output logic             host_irq,
  output logic             local_irq,
  output logic             local_syserr_out_n,
  output logic [3:0]       dma_read_cmd,
  output logic [3:0]       dma_write_cmd,
  output logic [3:0]       direct_read_cmd,
  output logic [3:0]       direct_write_cmd,
  output logic             gp_output_pin,
  input  wire logic        gp_input_pin,
  output logic             rom_clk_pin,
  output logic             rom_sel_pin,
  output logic             rom_data_out_pin,
  input  wire logic        rom_data_in_pin,
  input  wire logic        rom_detect_pin,
  output logic             reload_start,
  input  wire logic        reload_done,
  output logic             local_reset_out_n,
  input  wire logic        init_bypass_n
);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [4:0] pins_s;
  logic       lin_s;
  logic       gp_in_s;
  logic       rom_do_s;
  logic       rom_pres_s;
  logic       bypass_n_s;

  pin_sync3 #(.W(5)) u_sync (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .pin_in    ({init_bypass_n, rom_detect_pin, rom_data_in_pin, gp_input_pin, local_irq_pin}),
    .reset_val (5'h10),
    .level_out (pins_s)
  );
  assign lin_s      = pins_s[0];
  assign gp_in_s    = pins_s[1];
  assign rom_do_s   = pins_s[2];
  assign rom_pres_s = pins_s[3];
  assign bypass_n_s = pins_s[4];

  // ********************************
  // Register state and decode
  // ********************************
  logic [31:0] ics_r;
  logic [31:0] eio_r;
  logic [31:0] lbell_r;
  logic [31:0] hbell_r;
  logic        owner_r;
  logic        retry_flag_r;
  logic        abort_d_r;
  logic [8:0]  retry_cnt_r;
  logic        soft_rst;

  assign soft_rst = eio_r[B_SOFT_RST];

  function automatic logic hit(input logic sel, input logic wr, input logic [7:0] a,
                               input logic [7:0] off);
    hit = sel & wr & (a == off);
  endfunction : hit

  logic h_ics;
  logic h_eio;
  logic h_lb;
  logic h_hb;
  logic l_ics;
  logic l_eio;
  logic l_lb;
  logic l_hb;

  // Local port writes are ignored while the local side is held in soft reset
  assign h_ics = hit(host_sel, host_wr, host_addr, OFF_ICS_HOST);
  assign h_eio = hit(host_sel, host_wr, host_addr, OFF_EIO_HOST);
  assign h_lb  = hit(host_sel, host_wr, host_addr, OFF_LBELL_HOST);
  assign h_hb  = hit(host_sel, host_wr, host_addr, OFF_HBELL_HOST);
  assign l_ics = hit(loc_sel, loc_wr, loc_addr, OFF_ICS_LOC) & ~soft_rst;
  assign l_eio = hit(loc_sel, loc_wr, loc_addr, OFF_EIO_LOC) & ~soft_rst;
  assign l_lb  = hit(loc_sel, loc_wr, loc_addr, OFF_LBELL_LOC) & ~soft_rst;
  assign l_hb  = hit(loc_sel, loc_wr, loc_addr, OFF_HBELL_LOC) & ~soft_rst;

  // ********************************
  // Doorbells
  // ********************************
  logic [31:0] lbell_nxt;
  logic [31:0] hbell_nxt;

  // Set applied after clear so a same-cycle ring is never lost
  always_comb begin
    lbell_nxt = lbell_r;
    hbell_nxt = hbell_r;
    if (l_lb) lbell_nxt = lbell_nxt & ~loc_wdata;
    if (h_lb) lbell_nxt = lbell_nxt | host_wdata;
    if (h_hb) hbell_nxt = hbell_nxt & ~host_wdata;
    if (l_hb) hbell_nxt = hbell_nxt | loc_wdata;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lbell_r <= '0;
      hbell_r <= '0;
    end else begin
      lbell_r <= lbell_nxt;
      hbell_r <= hbell_nxt;
    end
  end

  // ********************************
  // Interrupt control register
  // ********************************
  // Host write wins a same-cycle collision with the local side
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ics_r <= ICS_RESET;
    end else if (h_ics) begin
      ics_r <= host_wdata & ICS_WR_MASK;
    end else if (l_ics) begin
      ics_r <= loc_wdata & ICS_WR_MASK;
    end
  end

  // ********************************
  // Retry limit and abort flags
  // ********************************
  logic retry_hit;
  assign retry_hit = ics_r[B_RETRY_EN] & retry_seen & (retry_cnt_r == RETRY_LIMIT - 9'h001);

  // Without the enable the count saturates, master keeps retrying
  always_ff @(posedge clock) begin
    if (sys_rst || xfer_done || retry_hit) begin
      retry_cnt_r <= '0;
    end else if (retry_seen && retry_cnt_r != RETRY_LIMIT - 9'h001) begin
      retry_cnt_r <= retry_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      retry_abort <= 1'b0;
    end else begin
      retry_abort <= retry_hit;
    end
  end

  // Hardware event beats a software write to the flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      retry_flag_r <= 1'b0;
    end else if (retry_hit) begin
      retry_flag_r <= 1'b0;
    end else if (h_ics) begin
      retry_flag_r <= host_wdata[B_RETRY_ABORT];
    end else if (l_ics) begin
      retry_flag_r <= loc_wdata[B_RETRY_ABORT];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      abort_d_r <= 1'b0;
      owner_r   <= 1'b0;
    end else begin
      abort_d_r <= abort_status;
      if (abort_status && !abort_d_r) begin
        owner_r <= ~abort_by_direct;
      end
    end
  end

  // ********************************
  // Serial ROM and I/O control register
  // ********************************
  logic reload_go;
  logic eio_wr;
  logic [31:0] eio_wd;
  assign eio_wr = h_eio | l_eio;
  assign eio_wd = h_eio ? host_wdata : loc_wdata;
  assign reload_go = eio_wr & eio_wd[B_RELOAD] & ~eio_r[B_RELOAD];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      eio_r <= EIO_RESET;
    end else begin
      if (eio_wr) begin
        eio_r[15:0]                  <= eio_wd[15:0];
        eio_r[B_GP_OUT]              <= eio_wd[B_GP_OUT];
        eio_r[B_ROM_WR:B_ROM_CLK]    <= eio_wd[B_ROM_WR:B_ROM_CLK];
      end
      if (reload_go) begin
        eio_r[B_RELOAD] <= 1'b1;
      end else if (reload_done) begin
        eio_r[B_RELOAD] <= 1'b0;
      end
      if (h_eio) begin
        eio_r[B_SOFT_RST] <= host_wdata[B_SOFT_RST];
      end
      if (!bypass_n_s) begin
        eio_r[B_INIT_DONE] <= 1'b1;
      end else if (eio_wr) begin
        eio_r[B_INIT_DONE] <= eio_wd[B_INIT_DONE];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reload_start <= 1'b0;
    end else begin
      reload_start <= reload_go;
    end
  end

  assign dma_read_cmd      = eio_r[3:0];
  assign dma_write_cmd     = eio_r[7:4];
  assign direct_read_cmd   = eio_r[11:8];
  assign direct_write_cmd  = eio_r[15:12];
  assign gp_output_pin     = eio_r[B_GP_OUT];
  assign rom_clk_pin       = eio_r[B_ROM_CLK];
  assign rom_sel_pin       = eio_r[B_ROM_SEL];
  assign rom_data_out_pin  = eio_r[B_ROM_WR];
  assign local_reset_out_n = ~soft_rst;
  assign host_retry        = host_sel & ~eio_r[B_INIT_DONE];

  // ********************************
  // Interrupt outputs
  // ********************************
  logic host_bell_act;
  logic loc_bell_act;
  assign host_bell_act = |hbell_r;
  assign loc_bell_act  = |lbell_r;

  // Registered so the pins never glitch on register writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      host_irq           <= 1'b0;
      local_irq          <= 1'b0;
      local_syserr_out_n <= 1'b1;
    end else begin
      host_irq <= ics_r[B_HOST_MASTER] &
                  ((ics_r[B_HOST_BELL_EN] & host_bell_act) |
                   (ics_r[B_ABORT_EN] & abort_status) |
                   (ics_r[B_LIN_EN] & lin_s));
      local_irq <= ics_r[B_LOC_MASTER] &
                   ((ics_r[B_LOC_BELL_EN] & loc_bell_act) |
                    (ics_r[B_CH0_EN] & chan0_status) |
                    (ics_r[B_CH1_EN] & chan1_status) |
                    selftest_bit);
      local_syserr_out_n <= ~(ics_r[B_SYSERR_EN] & abort_status);
    end
  end

  // ********************************
  // Read-back
  // ********************************
  function automatic logic [31:0] read_word(input logic [7:0] a, input logic loc);
    logic [31:0] ics_v;
    logic [31:0] eio_v;
    ics_v = ics_r;
    ics_v[B_HOST_BELL_ACT] = host_bell_act;
    ics_v[B_ABORT_ACT]     = abort_status;
    ics_v[B_LIN_ACT]       = lin_s;
    ics_v[B_LOC_BELL_ACT]  = loc_bell_act;
    ics_v[B_CH0_ACT]       = chan0_status;
    ics_v[B_CH1_ACT]       = chan1_status;
    ics_v[B_SELFTEST_ACT]  = selftest_bit;
    ics_v[B_ABORT_OWNER]   = owner_r;
    ics_v[B_RETRY_ABORT]   = retry_flag_r;
    eio_v = eio_r;
    eio_v[B_GP_IN]    = gp_in_s;
    eio_v[B_ROM_RD]   = rom_do_s;
    eio_v[B_ROM_PRES] = rom_pres_s;
    case (a)
      OFF_LBELL_HOST, OFF_LBELL_LOC: read_word = lbell_r;
      OFF_HBELL_HOST, OFF_HBELL_LOC: read_word = hbell_r;
      OFF_ICS_HOST, OFF_ICS_LOC:     read_word = ics_v;
      OFF_EIO_HOST, OFF_EIO_LOC:     read_word = eio_v;
      default:                       read_word = '0;
    endcase
    if (loc ^ a[7]) begin
      read_word = '0;
    end
  endfunction : read_word

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      host_rdata <= '0;
      loc_rdata  <= '0;
    end else begin
      if (host_sel && !host_wr) host_rdata <= read_word(host_addr, 1'b0);
      if (loc_sel && !loc_wr)   loc_rdata  <= read_word(loc_addr, 1'b1);
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_bell_rung;
    ics_r[B_HOST_MASTER] && ics_r[B_HOST_BELL_EN] && host_bell_act;
  endsequence

  a_host_master_gate: assert property (!ics_r[B_HOST_MASTER] |=> !host_irq)
    else $error("host irq without master enable");
  a_host_bell_irq: assert property (s_bell_rung |=> host_irq)
    else $error("host doorbell did not interrupt");
  a_abort_irq: assert property (ics_r[B_HOST_MASTER] && ics_r[B_ABORT_EN] && abort_status
                                |=> host_irq)
    else $error("abort did not interrupt");
  a_local_input_irq: assert property ($fell(lin_s) && !abort_status && !host_bell_act
                                      |=> !host_irq)
    else $error("host irq held after local input fell");
  a_retry_limit: assert property (retry_hit |=> retry_abort ##1 !retry_abort)
    else $error("retry abort not a single pulse");
  a_no_retry_abort: assert property (!ics_r[B_RETRY_EN] |=> !retry_abort)
    else $error("retry abort while disabled");
  a_chan_irq: assert property (ics_r[B_LOC_MASTER] && ics_r[B_CH0_EN] && chan0_status
                               |=> local_irq)
    else $error("channel 0 did not interrupt");
  a_retry_flag_clear: assert property (retry_hit |=> !retry_flag_r)
    else $error("retry flag not cleared");
  a_soft_rst_hold: assert property (soft_rst && !h_eio |=> soft_rst && !local_reset_out_n)
    else $error("soft reset released without host write");
  a_bypass_done: assert property (!bypass_n_s |=> eio_r[B_INIT_DONE] ##0 !host_retry)
    else $error("init done not forced by bypass");
  a_bell_set_wins: assert property (l_hb && h_hb && (loc_wdata[0] == 1'b1)
                                    |=> hbell_r[0])
    else $error("doorbell set lost to clear");
  a_syserr: assert property (ics_r[B_SYSERR_EN] && abort_status |=> !local_syserr_out_n)
    else $error("system error not asserted");

endmodule : bridge_interrupt_eeprom_control

/* File: logic/pin_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Stage one feeds stage two only
  always_ff @(posedge clock) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Per-bit agreement between stages two and three
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level_out <= reset_val;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : pin_sync3
